// ### src/plci_pkg.sv
// Package for the port link-change interrupt block: register offsets, widths, reset values.
// Assumes an 8-bit register access port with byte addresses as used by the switch's register map.
package plci_pkg;
  localparam int          PORTS        = 4;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 8;
  localparam logic [7:0]  PENDING_ADDR = 8'h7c;
  localparam logic [7:0]  SUPPRESS_ADDR = 8'h7d;
  localparam logic [3:0]  PORT_RESET   = 4'h0;
  localparam logic [3:0]  RSVD_BITS    = 4'h0;
  localparam logic [7:0]  RDATA_IDLE   = 8'h00;
  // Edges after reset before the link compare is trusted: two sync stages and last_q.
  localparam int          PRIME_DEPTH  = 3;
endpackage

// ### src/plci_sync.sv
// Two-stage synchroniser per port with a link-change detector on the synchronised level.
// Assumes the link state inputs are asynchronous to core_clk.
module plci_sync (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  // Link state in, change pulse out
  input  wire logic [plci_pkg::PORTS-1:0] link_up,
  output wire logic [plci_pkg::PORTS-1:0] link_chg
);
  logic [plci_pkg::PORTS-1:0]       meta_q;
  logic [plci_pkg::PORTS-1:0]       sync_q;
  logic [plci_pkg::PORTS-1:0]       last_q;
  logic [plci_pkg::PRIME_DEPTH-1:0] prime_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= plci_pkg::PORT_RESET;
      sync_q <= plci_pkg::PORT_RESET;
    end
    else
    begin
      meta_q <= link_up;
      sync_q <= meta_q;
    end
  end

  // A port may already be up at release, so the compare starts only once both sync
  // stages and last_q hold a post-reset sample; that level is the baseline, not a change.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_q  <= plci_pkg::PORT_RESET;
      prime_q <= {plci_pkg::PRIME_DEPTH{1'b0}};
    end
    else
    begin
      last_q  <= sync_q;
      prime_q <= {prime_q[plci_pkg::PRIME_DEPTH-2:0], 1'b1};
    end
  end

  genvar g;
  generate
    for (g = 0; g < plci_pkg::PORTS; g++)
    begin : g_chg
      assign link_chg[g] = prime_q[plci_pkg::PRIME_DEPTH-1] & (sync_q[g] ^ last_q[g]);
    end
  endgenerate
endmodule

// ### src/plci_top.sv
// Link-change interrupt collector for four network ports: pending and suppress registers.
// Assumes the switch's register access port presents one byte access per cycle on core_clk.

// Summary of operation
// - A link change on port N sets pending bit N-1, ports one to four on bits 0 to 3.
// - A pending bit reads one while its port has a change outstanding, even when its suppress bit is set, otherwise zero.
// - Writing one to a pending bit clears only that bit, and only a new change sets it again.
// - Each port has a read-write suppress bit at the same position that masks its request.
// - After reset all pending and suppress bits are zero and bits 7 to 4 read as zero.
module plci_top (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  // Port link state, asynchronous
  input  wire logic [plci_pkg::PORTS-1:0]  link_up,
  // Register access port
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [plci_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [plci_pkg::DATA_W-1:0] reg_wdata,
  output logic      [plci_pkg::DATA_W-1:0] reg_rdata,
  // Interrupt to host
  output logic                             irq
);
  logic [plci_pkg::PORTS-1:0] link_chg;
  logic [plci_pkg::PORTS-1:0] pending_q;
  wire  [plci_pkg::PORTS-1:0] pending_d;
  wire  [plci_pkg::PORTS-1:0] req_d;
  logic [plci_pkg::PORTS-1:0] suppress_q;
  logic [plci_pkg::PORTS-1:0] clr;
  logic                       wr_pend;
  logic                       wr_supp;
  logic                       irq_q;
  logic                       boot_q;

  plci_sync u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .link_up  (link_up),
    .link_chg (link_chg)
  );

  assign wr_pend = reg_wr && (reg_addr == plci_pkg::PENDING_ADDR);
  assign wr_supp = reg_wr && (reg_addr == plci_pkg::SUPPRESS_ADDR);
  assign clr     = wr_pend ? reg_wdata[plci_pkg::PORTS-1:0] : plci_pkg::PORT_RESET;

  // A change arriving in the same cycle as its clear wins, so no event is lost.
  genvar g;
  generate
    for (g = 0; g < plci_pkg::PORTS; g++)
    begin : g_pend
      assign pending_d[g] = link_chg[g] | (pending_q[g] & ~clr[g]);
      assign req_d[g]     = pending_d[g] & ~suppress_q[g];
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pending_q <= plci_pkg::PORT_RESET;
    else
      pending_q <= pending_d;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      suppress_q <= plci_pkg::PORT_RESET;
    else if (wr_supp)
      suppress_q <= reg_wdata[plci_pkg::PORTS-1:0];
  end

  // Registered from the next pending value, so it moves on the same edge as pending_q
  // and the host never sees a glitch.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else
      irq_q <= |req_d;
  end

  assign irq = irq_q;

  // Read data is registered and appears the cycle after reg_rd; other addresses read zero.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= plci_pkg::RDATA_IDLE;
    else if (reg_rd)
    begin
      case (reg_addr)
        plci_pkg::PENDING_ADDR:  reg_rdata <= {plci_pkg::RSVD_BITS, pending_q};
        plci_pkg::SUPPRESS_ADDR: reg_rdata <= {plci_pkg::RSVD_BITS, suppress_q};
        default:                 reg_rdata <= plci_pkg::RDATA_IDLE;
      endcase
    end
  end

  pend_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    link_chg[0] |=> pending_q[0])
    else $error("pending bit 0 not set by link change");

  pend_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_pend && reg_wdata[1] && !link_chg[1]) |=> !pending_q[1])
    else $error("pending bit 1 not cleared by write of one");

  pend_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pending_q[2] && !(wr_pend && reg_wdata[2])) |=> pending_q[2])
    else $error("pending bit 2 lost without a clear");

  pend_noset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!pending_q[3] && !link_chg[3]) |=> !pending_q[3])
    else $error("pending bit 3 set without a link change");

  read_pend_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == plci_pkg::PENDING_ADDR) |=>
      reg_rdata == {plci_pkg::RSVD_BITS, $past(pending_q)})
    else $error("pending read data wrong");

  supp_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_supp |=> suppress_q == $past(reg_wdata[plci_pkg::PORTS-1:0]))
    else $error("suppress write not taken");

  rsvd_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rdata[7:4] == plci_pkg::RSVD_BITS)
    else $error("reserved bits not zero");

  irq_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 irq == |($past(pending_d) & ~$past(suppress_q)))
    else $error("interrupt output disagrees with pending and suppress");

  // Helper flag, high only up to the first edge after reset is released, so that the
  // reset values can be checked at a sampling edge.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      boot_q <= 1'b1;
    else
      boot_q <= 1'b0;
  end

  reset_vals_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    boot_q |->
      (pending_q == plci_pkg::PORT_RESET) && (suppress_q == plci_pkg::PORT_RESET) && !irq)
    else $error("registers not at reset value after reset");

  // Whole-vector checks, so that every port is covered and not only one sample bit.
  pend_set_all_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (|link_chg)
    |=> ((pending_q & $past(link_chg)) == $past(link_chg)))
    else $error("pending bit not set by a link change");

  pend_clr_all_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_pend
    |=> ((pending_q & $past(clr) & ~$past(link_chg)) == plci_pkg::PORT_RESET))
    else $error("pending bit written with one not cleared");

  pend_hold_all_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1
    |=> ((~pending_q & $past(pending_q) & ~$past(clr)) == plci_pkg::PORT_RESET))
    else $error("pending bit dropped without a clear");

  pend_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1
    |=> ((pending_q & ~$past(pending_q) & ~$past(link_chg)) == plci_pkg::PORT_RESET))
    else $error("pending bit set without a link change");

  // Register port behaviour.
  supp_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !wr_supp
    |=> $stable(suppress_q))
    else $error("suppress changed without a write");

  supp_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == plci_pkg::SUPPRESS_ADDR)
    |=> reg_rdata == {plci_pkg::RSVD_BITS, $past(suppress_q)})
    else $error("suppress read data wrong");

  rdata_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !reg_rd
    |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  other_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr != plci_pkg::PENDING_ADDR &&
      reg_addr != plci_pkg::SUPPRESS_ADDR)
    |=> reg_rdata == plci_pkg::RDATA_IDLE)
    else $error("unmapped read not zero");

  // Interrupt output against pending and suppress.
  irq_masked_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (&suppress_q)
    |=> !irq)
    else $error("interrupt raised while every port is suppressed");

  irq_raise_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (|(pending_q & ~suppress_q & ~clr))
    |=> irq)
    else $error("interrupt missing for an unsuppressed pending bit");

  irq_drop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ((pending_d & ~suppress_q) == plci_pkg::PORT_RESET)
    |=> !irq)
    else $error("interrupt held with no unsuppressed pending bit");

  // Per-port checks of the read-back and of a suppress bit written with zero.
  generate
    for (g = 0; g < plci_pkg::PORTS; g++)
    begin : g_chk
      read_bit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == plci_pkg::PENDING_ADDR)
        |=> reg_rdata[g] == $past(pending_q[g]))
        else $error("pending bit read back wrong");

      supp_bit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr_supp && !reg_wdata[g])
        |=> !suppress_q[g])
        else $error("suppress bit not cleared by write of zero");
    end
  endgenerate
endmodule

// ### verification/plci_host.sv
// Host model: makes one byte access at a time on the register port.
// Assumes core_clk from the bench; requests change 1 ns after a rising edge.
module plci_host (
  // Clock
  input  wire logic       core_clk,
  // Register access port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Idle address and data are inverted so a stale value never looks valid.
  task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge core_clk) #1;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk) #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    q = reg_rdata;
  endtask
endmodule

// ### verification/port_link_change_interrupt_bench.sv
// Self-checking bench for the link-change interrupt collector.
// Assumes a 250 MHz core clock and the host model on the register port.
module port_link_change_interrupt_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, rst_n = 1'b0, reg_wr, reg_rd, irq;
  logic [3:0] link_up = 4'h0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  always #2 core_clk = ~core_clk;
  plci_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .link_up(link_up), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .irq(irq));
  plci_host host_u (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  task automatic chk(input string n, input logic [7:0] e, s);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    host_u.acc(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, e);
    host_u.acc(1'b0, a, 8'h00, q);
    chk("reg_rdata", e, q);
  endtask
  task automatic ci(input logic [7:0] e);
    chk("irq", e, 8'(irq));
  endtask
  // Five cycles covers the two sync flops, the detector and the pending flop.
  task automatic flip(input int n);
    @(posedge core_clk) #1;
    link_up[n] = ~link_up[n];
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge core_clk);
    rc(8'h7c, 8'h00);
    rc(8'h7d, 8'h00);
    ci(8'h00);
    wr(8'h7d, 8'hff);
    rc(8'h7d, 8'h0f);
    wr(8'h7e, 8'hff);
    rc(8'h7e, 8'h00);
    rc(8'h7c, 8'h00);
    for (int n = 0; n < 4; n++)
    begin
      flip(n);
      rc(8'h7c, 8'((9'h002 << n) - 9'h001));
      ci(8'h00);
    end
    wr(8'h7d, 8'h07);
    rc(8'h7d, 8'h07);
    ci(8'h01);
    wr(8'h7c, 8'hf9);
    rc(8'h7c, 8'h06);
    ci(8'h00);
    wr(8'h7d, 8'h00);
    rc(8'h7c, 8'h06);
    ci(8'h01);
    wr(8'h7c, 8'h06);
    repeat (5) rc(8'h7c, 8'h00);
    ci(8'h00);
    // Reset again with three ports up: their level must be a baseline, not a change.
    wr(8'h7d, 8'h0f);
    flip(0);
    rc(8'h7c, 8'h01);
    @(posedge core_clk) #1 rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    rc(8'h7d, 8'h00);
    rc(8'h7c, 8'h00);
    ci(8'h00);
    wrap_up();
  end
endmodule
